//--- shared/shmb_pkg.sv
// shared constants and types for the sensor host mailbox register slice
package shmb_pkg;

  // ************************************************************
  // link framing
  // ************************************************************
  localparam logic [6:0] DEV_ADDR    = 7'h5A; // arbitrary value, bus address of the device
  localparam logic [3:0] BIT_LAST    = 4'h7;  // last data bit of a byte
  localparam logic [3:0] BIT_ACK     = 4'h8;  // acknowledge slot
  localparam logic [3:0] BIT_RESYNC  = 4'h3;  // bit count once a start has crossed over
  localparam logic [3:0] LINK_RST_CNT = 4'hF; // core cycles the link reset request outlasts reset

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_PROX2_TH   = 8'h13;
  localparam logic [7:0] OFS_PROX3_TH   = 8'h15;
  localparam logic [7:0] OFS_PARAM_WRITE_MAILBOX   = 8'h17;
  localparam logic [7:0] OFS_COMMAND    = 8'h18;
  localparam logic [7:0] OFS_RESPONSE   = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h21;
  localparam logic [7:0] OFS_VIS_LO     = 8'h22;
  localparam logic [7:0] OFS_VIS_HI     = 8'h23;
  localparam logic [7:0] OFS_IR_LO      = 8'h24;

  // ************************************************************
  // reset values and field layout
  // ************************************************************
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;
  localparam logic [7:0] STATUS_MASK    = 8'h3F; // bits 7:6 reserved, read zero
  localparam int         BIT_CMD_IRQ    = 5;
  localparam int         BIT_PROX3_IRQ  = 4;
  localparam int         BIT_PROX2_IRQ  = 3;
  localparam int         BIT_PROX1_IRQ  = 2;
  localparam logic [1:0] PROX_IM_HOLD   = 2'h3;  // prox mode that survives auto clear

  // ************************************************************
  // commands and response codes
  // ************************************************************
  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_RESET      = 8'h01;
  localparam logic [7:0] RSP_INVALID    = 8'h80;
  localparam logic [7:0] RSP_OVF_PROX   = 8'h88; // plus channel 0..2
  localparam logic [7:0] RSP_OVF_AMB    = 8'h8C; // plus channel 3..5 minus 3

  // ************************************************************
  // measurement channel numbers
  // ************************************************************
  localparam logic [2:0] CH_PROX1 = 3'h0;
  localparam logic [2:0] CH_PROX2 = 3'h1;
  localparam logic [2:0] CH_PROX3 = 3'h2;
  localparam logic [2:0] CH_VIS   = 3'h3;
  localparam logic [2:0] CH_IR    = 3'h4;
  localparam logic [2:0] CH_AUX   = 3'h5;

  // link phase along a transfer
  typedef enum logic [2:0] {
    PH_ADDR   = 3'h0,
    PH_PTR    = 3'h1,
    PH_WDATA  = 3'h3,
    PH_READ   = 3'h2,
    PH_IGNORE = 3'h6
  } shmb_phase_t;

endpackage : shmb_pkg

//--- hw/shmb_regs.sv
// register slice with serial link front end, command mailbox and interrupt status
module shmb_regs (
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  input  wire logic        SCL,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  output logic             INT_N,
  output logic             AWAKE,
  input  wire logic        SLEEP_REQ,
  output logic             CMD_STROBE,
  output logic [7:0]       CMD_CODE,
  output logic [7:0]       PARAM_BYTE,
  input  wire logic        CMD_DONE,
  input  wire logic        CMD_INVALID,
  input  wire logic        ADC_OVF,
  input  wire logic [2:0]  ADC_OVF_CH,
  input  wire logic        MEAS_VALID,
  input  wire logic [2:0]  MEAS_CH,
  input  wire logic [15:0] MEAS_DATA,
  input  wire logic        PROX1_HIT,
  input  wire logic [1:0]  AMB_IRQ,
  input  wire logic        AUTO_CLEAR,
  input  wire logic [5:0]  IRQ_ENABLE,
  input  wire logic        INT_MODE,
  input  wire logic [5:0]  PROX_IRQ_MODE
);

  // ************************************************************
  // helper functions
  // ************************************************************

  // expand compressed threshold: high nibble exponent, low nibble mantissa
  function automatic logic [15:0] expand_th(input logic [7:0] code);
    logic [15:0] full;
    full = {1'b1, code[3:0], 11'h000};
    if (code[7:4] == 4'h0)
      return 16'h0000;
    return full >> (4'hF - code[7:4]);
  endfunction : expand_th

  // commands still accepted while an error is held
  function automatic logic is_hold_cmd(input logic [7:0] code);
    return (code == shmb_pkg::CMD_NOP) || (code == shmb_pkg::CMD_RESET);
  endfunction : is_hold_cmd

  // overflow channel to response code
  function automatic logic [7:0] ovf_code(input logic [2:0] ch);
    if (ch <= shmb_pkg::CH_PROX3)
      return 8'(shmb_pkg::RSP_OVF_PROX + {5'h00, ch});
    return 8'(shmb_pkg::RSP_OVF_AMB + {5'h00, ch} - 8'h03);
  endfunction : ovf_code

  // ************************************************************
  // link domain, rising edge of the link clock
  // ************************************************************
  typedef struct packed {
    logic              rst_s1;
    logic              rst_s2;
    logic              st_s1;
    logic              st_s2;
    logic              st_seen;
    logic [3:0]        cnt;
    logic [7:0]        shift;
    shmb_pkg::shmb_phase_t phase;
    logic              ack;
    logic [7:0]        ptr;
    logic [7:0]        wr_addr;
    logic [7:0]        wr_data;
    logic              wr_tgl;
    logic              ptr_tgl;
  } shmb_link_t;

  // link domain, falling edge: pin drive only
  typedef struct packed {
    logic              oe;
    logic              out;
  } shmb_pin_t;

  // core domain state
  typedef struct packed {
    logic              scl_s1;
    logic              scl_s2;
    logic              scl_d;
    logic              sda_s1;
    logic              sda_s2;
    logic              sda_d;
    logic              start_tgl;
    logic              wr_s1;
    logic              wr_s2;
    logic              wr_seen;
    logic              ptr_s1;
    logic              ptr_s2;
    logic              ptr_seen;
    logic [7:0]        ptr_copy;
    logic [7:0]        rd_byte;
    logic [7:0]        th2;
    logic [7:0]        th3;
    logic [7:0]        param;
    logic [7:0]        cmd;
    logic [7:0]        resp;
    logic [7:0]        status;
    logic [7:0]        vis_lo;
    logic [7:0]        vis_hi;
    logic [7:0]        ir_lo;
    logic              awake;
    logic              strobe;
    logic              int_n;
    logic [3:0]        link_hold;
  } shmb_core_t;

  shmb_link_t lk_reg, lk_next;
  shmb_pin_t  pn_reg, pn_next;
  shmb_core_t cr_reg, cr_next;

  logic        wr_evt;
  logic        cmd_wr;
  logic        err_held;
  logic        cmd_pass;

  // ************************************************************
  // link byte engine
  // ************************************************************

  // shift address, pointer and data bytes in on the rising edge
  always_comb
  begin
    logic [7:0] byte_in;
    byte_in = {lk_reg.shift[6:0], SDA_IN};
    lk_next = lk_reg;
    lk_next.rst_s1 = (cr_reg.link_hold != 4'h0); // stretched so slow link clocks still see it
    lk_next.rst_s2 = lk_reg.rst_s1;
    lk_next.st_s1 = cr_reg.start_tgl;
    lk_next.st_s2 = lk_reg.st_s1;
    lk_next.shift = byte_in;
    lk_next.cnt = (lk_reg.cnt == shmb_pkg::BIT_ACK) ? 4'h0 : 4'(lk_reg.cnt + 4'h1);
    // host refuses further read bytes
    if (lk_reg.cnt == shmb_pkg::BIT_ACK && lk_reg.phase == shmb_pkg::PH_READ && SDA_IN)
      lk_next.phase = shmb_pkg::PH_IGNORE;
    if (lk_reg.cnt == shmb_pkg::BIT_LAST)
    begin
      lk_next.ack = 1'b0;
      case (lk_reg.phase)
        shmb_pkg::PH_ADDR:
        begin
          if (byte_in[7:1] == shmb_pkg::DEV_ADDR)
          begin
            lk_next.ack = 1'b1;
            lk_next.phase = byte_in[0] ? shmb_pkg::PH_READ : shmb_pkg::PH_PTR;
          end
          else
            lk_next.phase = shmb_pkg::PH_IGNORE;
        end
        shmb_pkg::PH_PTR:
        begin
          lk_next.ack = 1'b1;
          lk_next.ptr = byte_in;
          lk_next.ptr_tgl = !lk_reg.ptr_tgl;
          lk_next.phase = shmb_pkg::PH_WDATA;
        end
        shmb_pkg::PH_WDATA:
        begin
          // byte handed to the core by toggle, held for a whole byte time
          lk_next.ack = 1'b1;
          lk_next.wr_addr = lk_reg.ptr;
          lk_next.wr_data = byte_in;
          lk_next.wr_tgl = !lk_reg.wr_tgl;
          lk_next.ptr = 8'(lk_reg.ptr + 8'h01);
        end
        default:
          lk_next.ack = 1'b0;
      endcase
    end
    // start seen by the core: realign to the address byte
    if (lk_reg.st_s2 != lk_reg.st_seen)
    begin
      lk_next.st_seen = lk_reg.st_s2;
      lk_next.phase = shmb_pkg::PH_ADDR;
      lk_next.cnt = shmb_pkg::BIT_RESYNC;
    end
    if (lk_reg.rst_s2)
    begin
      lk_next.cnt = 4'h0;
      lk_next.phase = shmb_pkg::PH_IGNORE;
      lk_next.ack = 1'b0;
      lk_next.st_seen = lk_reg.st_s2;
      lk_next.wr_tgl = 1'b0;
      lk_next.ptr_tgl = 1'b0;
    end
  end

  // link state register
  always_ff @(posedge SCL)
  begin
    lk_reg <= lk_next;
  end

  // drive acknowledge and read data while the link clock is low
  always_comb
  begin
    logic [2:0] idx;
    idx = 3'(4'h7 - lk_reg.cnt);
    pn_next.out = 1'b0;
    pn_next.oe = 1'b0;
    if (lk_reg.cnt == shmb_pkg::BIT_ACK)
      pn_next.oe = lk_reg.ack;
    else if (lk_reg.phase == shmb_pkg::PH_READ)
      pn_next.oe = !cr_reg.rd_byte[idx];
    if (lk_reg.rst_s2)
      pn_next.oe = 1'b0;
  end

  // pin register
  always_ff @(negedge SCL)
  begin
    pn_reg <= pn_next;
  end

  // ************************************************************
  // core registers
  // ************************************************************

  // write event and command gating
  assign wr_evt   = CE && (cr_reg.wr_s2 != cr_reg.wr_seen);
  assign cmd_wr   = wr_evt && (lk_reg.wr_addr == shmb_pkg::OFS_COMMAND);
  assign err_held = cr_reg.resp[7];
  assign cmd_pass = cmd_wr && (!err_held || is_hold_cmd(lk_reg.wr_data));

  // crossings, register writes, command mailbox, response and status
  always_comb
  begin
    logic [7:0] set_m;
    logic [7:0] clr_m;
    set_m = 8'h00;
    clr_m = 8'h00;
    cr_next = cr_reg;
    if (CE)
    begin
      cr_next.strobe = 1'b0;
      // link reset request runs out after reset
      if (cr_reg.link_hold != 4'h0)
        cr_next.link_hold = 4'(cr_reg.link_hold - 4'h1);
      cr_next.scl_s1 = SCL;
      cr_next.scl_s2 = cr_reg.scl_s1;
      cr_next.scl_d = cr_reg.scl_s2;
      cr_next.sda_s1 = SDA_IN;
      cr_next.sda_s2 = cr_reg.sda_s1;
      cr_next.sda_d = cr_reg.sda_s2;
      // start: data falls while the link clock stays high
      if (cr_reg.scl_s2 && cr_reg.scl_d && cr_reg.sda_d && !cr_reg.sda_s2)
        cr_next.start_tgl = !cr_reg.start_tgl;
      cr_next.wr_s1 = lk_reg.wr_tgl;
      cr_next.wr_s2 = cr_reg.wr_s1;
      cr_next.wr_seen = cr_reg.wr_s2;
      cr_next.ptr_s1 = lk_reg.ptr_tgl;
      cr_next.ptr_s2 = cr_reg.ptr_s1;
      cr_next.ptr_seen = cr_reg.ptr_s2;
      if (cr_reg.ptr_s2 != cr_reg.ptr_seen)
        cr_next.ptr_copy = lk_reg.ptr;
      // host writes
      if (wr_evt)
      begin
        case (lk_reg.wr_addr)
          shmb_pkg::OFS_PROX2_TH:   cr_next.th2 = lk_reg.wr_data;
          shmb_pkg::OFS_PROX3_TH:   cr_next.th3 = lk_reg.wr_data;
          shmb_pkg::OFS_PARAM_WRITE_MAILBOX:   cr_next.param = lk_reg.wr_data;
          shmb_pkg::OFS_RESPONSE:   cr_next.resp = lk_reg.wr_data;
          shmb_pkg::OFS_IRQ_STATUS: clr_m = lk_reg.wr_data;
          shmb_pkg::OFS_VIS_LO:     cr_next.vis_lo = lk_reg.wr_data;
          shmb_pkg::OFS_VIS_HI:     cr_next.vis_hi = lk_reg.wr_data;
          shmb_pkg::OFS_IR_LO:      cr_next.ir_lo = lk_reg.wr_data;
          default:                  cr_next.cmd = cr_reg.cmd;
        endcase
      end
      // command mailbox: wake, then forward unless blocked by an error
      if (cmd_wr)
      begin
        cr_next.cmd = lk_reg.wr_data;
        cr_next.awake = 1'b1;
      end
      else if (SLEEP_REQ)
        cr_next.awake = 1'b0;
      if (cmd_pass)
      begin
        cr_next.strobe = 1'b1;
        if (is_hold_cmd(lk_reg.wr_data))
          cr_next.resp = shmb_pkg::RST_BYTE;
      end
      // command completion and overflow: first error is kept
      if (!err_held && !cmd_pass)
      begin
        if (ADC_OVF)
          cr_next.resp = ovf_code(ADC_OVF_CH);
        else if (CMD_DONE && CMD_INVALID)
          cr_next.resp = shmb_pkg::RSP_INVALID;
        else if (CMD_DONE)
          cr_next.resp = {4'h0, 4'(cr_reg.resp[3:0] + 4'h1)};
      end
      if (CMD_DONE)
        set_m[shmb_pkg::BIT_CMD_IRQ] = 1'b1;
      // measurements run on regardless of the response state
      if (MEAS_VALID)
      begin
        case (MEAS_CH)
          shmb_pkg::CH_PROX2:
            set_m[shmb_pkg::BIT_PROX2_IRQ] = MEAS_DATA > expand_th(cr_reg.th2);
          shmb_pkg::CH_PROX3:
            set_m[shmb_pkg::BIT_PROX3_IRQ] = MEAS_DATA > expand_th(cr_reg.th3);
          shmb_pkg::CH_VIS:
          begin
            cr_next.vis_lo = MEAS_DATA[7:0];
            cr_next.vis_hi = MEAS_DATA[15:8];
          end
          shmb_pkg::CH_IR:
            cr_next.ir_lo = MEAS_DATA[7:0];
          default:
            cr_next.ir_lo = cr_next.ir_lo;
        endcase
      end
      set_m[shmb_pkg::BIT_PROX1_IRQ] = set_m[shmb_pkg::BIT_PROX1_IRQ] | PROX1_HIT;
      set_m[1:0] = AMB_IRQ;
      // automatic clearing keeps proximity flags in hold mode
      if (INT_MODE && AUTO_CLEAR)
      begin
        clr_m = 8'hFF;
        for (int i = 0; i < 3; i++)
          if (PROX_IRQ_MODE[2*i +: 2] == shmb_pkg::PROX_IM_HOLD)
            clr_m[shmb_pkg::BIT_PROX1_IRQ + i] = 1'b0;
      end
      // set wins over clear
      cr_next.status = ((cr_reg.status & ~clr_m) | set_m) & shmb_pkg::STATUS_MASK;
      cr_next.int_n = !(|(cr_reg.status[5:0] & IRQ_ENABLE));
      // byte offered to the link for reads
      case (cr_reg.ptr_copy)
        shmb_pkg::OFS_PROX2_TH:   cr_next.rd_byte = cr_reg.th2;
        shmb_pkg::OFS_PROX3_TH:   cr_next.rd_byte = cr_reg.th3;
        shmb_pkg::OFS_PARAM_WRITE_MAILBOX:   cr_next.rd_byte = cr_reg.param;
        shmb_pkg::OFS_COMMAND:    cr_next.rd_byte = cr_reg.cmd;
        shmb_pkg::OFS_RESPONSE:   cr_next.rd_byte = cr_reg.resp;
        shmb_pkg::OFS_IRQ_STATUS: cr_next.rd_byte = cr_reg.status;
        shmb_pkg::OFS_VIS_LO:     cr_next.rd_byte = cr_reg.vis_lo;
        shmb_pkg::OFS_VIS_HI:     cr_next.rd_byte = cr_reg.vis_hi;
        shmb_pkg::OFS_IR_LO:      cr_next.rd_byte = cr_reg.ir_lo;
        default:                  cr_next.rd_byte = shmb_pkg::UNMAPPED_READ;
      endcase
    end
    if (RESET)
    begin
      cr_next = '0;
      cr_next.int_n = 1'b1;
      cr_next.link_hold = shmb_pkg::LINK_RST_CNT;
    end
  end

  // core state register
  always_ff @(posedge REF_CLK)
  begin
    cr_reg <= cr_next;
  end

  // outputs straight from flops
  assign SDA_OUT    = pn_reg.out;
  assign SDA_OE     = pn_reg.oe;
  assign INT_N      = cr_reg.int_n;
  assign AWAKE      = cr_reg.awake;
  assign CMD_STROBE = cr_reg.strobe;
  assign CMD_CODE   = cr_reg.cmd;
  assign PARAM_BYTE = cr_reg.param;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  // host command arrives while an error is held
  sequence s_cmd_while_err;
    cmd_wr && err_held;
  endsequence

  // clean completion with no error present
  sequence s_clean_done;
    CE && CMD_DONE && !CMD_INVALID && !ADC_OVF && !err_held && !cmd_pass;
  endsequence

  AST_INT_FOLLOWS: assert property (
    CE ##1 CE |=> INT_N == !(|($past(cr_reg.status[5:0]) & $past(IRQ_ENABLE))))
    else $error("interrupt pin does not follow status and enable");

  AST_WAKE_ON_CMD: assert property (
    cmd_wr && !SLEEP_REQ |=> AWAKE)
    else $error("command write did not wake the device");

  AST_NO_WAKE_OTHER: assert property (
    CE && !AWAKE && !cmd_wr |=> !AWAKE)
    else $error("device woke without a command write");

  AST_BLOCK_CMD: assert property (
    s_cmd_while_err ##0 !is_hold_cmd(lk_reg.wr_data) |=> !CMD_STROBE && cr_reg.resp[7])
    else $error("command taken while an error was held");

  AST_HOLD_CLEARS: assert property (
    s_cmd_while_err ##0 is_hold_cmd(lk_reg.wr_data) |=> CMD_STROBE && cr_reg.resp == 8'h00)
    else $error("reset or no-operation did not clear the error");

  AST_ERR_KEPT: assert property (
    CE && err_held && !cmd_pass && !(wr_evt && lk_reg.wr_addr == shmb_pkg::OFS_RESPONSE)
    |=> $stable(cr_reg.resp))
    else $error("held error code changed");

  AST_INVALID_CODE: assert property (
    CE && CMD_DONE && CMD_INVALID && !ADC_OVF && !err_held && !cmd_pass
    |=> cr_reg.resp == 8'h80)
    else $error("invalid command not reported as 0x80");

  AST_OVF_CODE: assert property (
    CE && ADC_OVF && ADC_OVF_CH == 3'h4 && !err_held && !cmd_pass |=> cr_reg.resp == 8'h8D)
    else $error("infrared overflow code wrong");

  AST_COUNTER: assert property (
    s_clean_done |=> cr_reg.resp == {4'h0, 4'($past(cr_reg.resp[3:0]) + 4'h1)})
    else $error("response counter did not advance");

  AST_PROX2_FLAG: assert property (
    CE && MEAS_VALID && MEAS_CH == 3'h1 && MEAS_DATA > expand_th(cr_reg.th2)
    |=> cr_reg.status[3] ##1 !INT_N || !IRQ_ENABLE[3])
    else $error("channel two threshold crossing not flagged");

  AST_RESERVED_ZERO: assert property (
    CE |=> cr_reg.status[7:6] == 2'h0)
    else $error("reserved status bits set");

endmodule : shmb_regs

//--- verif/shmb_host_model.sv
// host link master model: makes the link clock and pulls the data wire low
module shmb_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 40; // quarter of the 160 ns link period

  // link clock stands high and data is released outside frames
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // one bit slot: data set mid low, sampled mid high
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_io

  // data falls while the clock is high, held 160 ns
  task automatic start_cond();
    #Q sda_low = 1'b1;
    #(4*Q) scl = 1'b0;
    #Q;
  endtask : start_cond

  // data rises while the clock is high
  task automatic stop_cond();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b0;
    #(2*Q);
  endtask : stop_cond

  // free link clocks with data released, lets the link reset take hold
  task automatic idle_clocks(input int n);
    sda_low = 1'b0;
    repeat (n)
    begin
      #(2*Q) scl = 1'b0;
      #(2*Q) scl = 1'b1;
    end
  endtask : idle_clocks

  // eight bits msb first, then the ack slot with the wire released
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(1'b1, ack);
  endtask : byte_io

  // pointer then one data byte
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] rx;
    logic       a;
    start_cond();
    byte_io({shmb_pkg::DEV_ADDR, 1'b0}, rx, a);
    byte_io(ptr, rx, a);
    byte_io(d, rx, a); // host places the data byte for the pointed register
    stop_cond();
  endtask : write_reg

  // pointer write, pause, then one byte read ended by a nack
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] rx;
    logic       a;
    start_cond();
    byte_io({shmb_pkg::DEV_ADDR, 1'b0}, rx, a);
    byte_io(ptr, rx, a);
    stop_cond();
    #400;
    start_cond();
    byte_io({shmb_pkg::DEV_ADDR, 1'b1}, rx, a);
    byte_io(8'hFF, d, a);
    stop_cond();
  endtask : read_reg
endmodule : shmb_host_model

//--- verif/shmb_regs_tb.sv
// self-checking bench for the sensor host mailbox register slice
module shmb_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        SCL, SDA_LOW, SDA_OE, INT_N, AWAKE, CMD_STROBE;
  logic [7:0]  CMD_CODE, PARAM_BYTE, d;
  logic        CMD_DONE = 1'b0, CMD_INVALID = 1'b0, ADC_OVF = 1'b0, MEAS_VALID = 1'b0;
  logic [2:0]  ADC_OVF_CH = 3'h0, MEAS_CH = 3'h0;
  logic [15:0] MEAS_DATA = 16'h0000;
  logic        PROX1_HIT = 1'b0, AUTO_CLEAR = 1'b0, INT_MODE = 1'b0;
  logic [1:0]  AMB_IRQ = 2'h0;
  logic [5:0]  IRQ_ENABLE = 6'h00, PROX_IRQ_MODE = 6'h00;
  int          n_errors = 0, tests_run = 0, n_strobe = 0, s;
  wire         sda = (SDA_OE === 1'b1 || SDA_LOW) ? 1'b0 : 1'b1; // pulled-up wire

  always #25 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) if (CMD_STROBE === 1'b1) n_strobe++;

  shmb_host_model u_host (.scl(SCL), .sda_low(SDA_LOW), .sda(sda));
  shmb_regs u_dut (.REF_CLK(REF_CLK), .RESET(RESET), .CE(1'b1), .SCL(SCL), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE(SDA_OE), .INT_N(INT_N), .AWAKE(AWAKE), .SLEEP_REQ(1'b0),
    .CMD_STROBE(CMD_STROBE), .CMD_CODE(CMD_CODE), .PARAM_BYTE(PARAM_BYTE),
    .CMD_DONE(CMD_DONE), .CMD_INVALID(CMD_INVALID), .ADC_OVF(ADC_OVF),
    .ADC_OVF_CH(ADC_OVF_CH), .MEAS_VALID(MEAS_VALID), .MEAS_CH(MEAS_CH),
    .MEAS_DATA(MEAS_DATA), .PROX1_HIT(PROX1_HIT), .AMB_IRQ(AMB_IRQ),
    .AUTO_CLEAR(AUTO_CLEAR), .IRQ_ENABLE(IRQ_ENABLE), .INT_MODE(INT_MODE),
    .PROX_IRQ_MODE(PROX_IRQ_MODE));

  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // byte compare
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // register read through the link, then compare
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    u_host.read_reg(ptr, d);
    chk($sformatf("reg %h", ptr), exp, d);
  endtask : rd

  // one-cycle sequencer event: auto clear, hits, measurement, overflow, done
  task automatic pulse(input logic [4:0] sel, input logic [2:0] ch, input logic [15:0] v);
    @(posedge REF_CLK);
    {AUTO_CLEAR, PROX1_HIT, MEAS_VALID, ADC_OVF, CMD_DONE} <= sel;
    AMB_IRQ <= {2{sel[3]}};
    ADC_OVF_CH <= ch;
    MEAS_CH <= ch;
    MEAS_DATA <= v;
    @(posedge REF_CLK);
    {AUTO_CLEAR, PROX1_HIT, MEAS_VALID, ADC_OVF, CMD_DONE} <= 5'h00;
    AMB_IRQ <= 2'h0;
    repeat (3) @(posedge REF_CLK);
  endtask : pulse

  task automatic t_reset();
    logic [7:0] ofs [5] = '{8'h15, 8'h17, 8'h21, 8'h23, 8'h24};
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    chk("awake", 8'h00, {7'h00, AWAKE});
  endtask : t_reset

  task automatic t_mailbox();
    u_host.write_reg(8'h17, 8'hA5);
    chk("param", 8'hA5, PARAM_BYTE);
    chk("awake", 8'h00, {7'h00, AWAKE});
    s = n_strobe;
    u_host.write_reg(8'h18, 8'h05);
    chk("strobes", 8'h01, 8'(n_strobe - s));
    chk("code", 8'h05, CMD_CODE);
    chk("awake", 8'h01, {7'h00, AWAKE});
    pulse(5'h01, 3'h0, 16'h0000);
    rd(8'h20, 8'h01);
    repeat (15) pulse(5'h01, 3'h0, 16'h0000);
    rd(8'h20, 8'h00);
  endtask : t_mailbox

  task automatic t_error();
    CMD_INVALID <= 1'b1;
    pulse(5'h01, 3'h0, 16'h0000);
    CMD_INVALID <= 1'b0;
    rd(8'h20, 8'h80);
    s = n_strobe;
    u_host.write_reg(8'h18, 8'h05);
    chk("strobes", 8'h00, 8'(n_strobe - s));
    rd(8'h20, 8'h80);
    pulse(5'h04, 3'h3, 16'h1234);
    pulse(5'h04, 3'h4, 16'h00AB);
    rd(8'h22, 8'h34);
    rd(8'h23, 8'h12);
    rd(8'h24, 8'hAB);
    u_host.write_reg(8'h18, 8'h00);
    rd(8'h20, 8'h00);
  endtask : t_error

  task automatic t_overflow();
    logic [7:0] code [6] = '{8'h88, 8'h89, 8'h8A, 8'h8C, 8'h8D, 8'h8E};
    foreach (code[i])
    begin
      pulse(5'h02, 3'(i), 16'h0000);
      rd(8'h20, code[i]);
      u_host.write_reg(8'h18, 8'h01);
    end
    rd(8'h20, 8'h00);
  endtask : t_overflow

  task automatic t_irq();
    u_host.write_reg(8'h21, 8'hFF);
    rd(8'h21, 8'h00);
    IRQ_ENABLE <= 6'h08;
    u_host.write_reg(8'h13, 8'hF1);
    pulse(5'h04, 3'h1, 16'h8800);
    rd(8'h21, 8'h00);
    chk("int_n", 8'h01, {7'h00, INT_N});
    pulse(5'h04, 3'h1, 16'h8801);
    rd(8'h21, 8'h08);
    chk("int_n", 8'h00, {7'h00, INT_N});
    u_host.write_reg(8'h21, 8'h08);
    rd(8'h21, 8'h00);
    chk("int_n", 8'h01, {7'h00, INT_N});
    INT_MODE <= 1'b1;
    PROX_IRQ_MODE <= 6'h30;
    pulse(5'h08, 3'h0, 16'h0000);
    pulse(5'h04, 3'h2, 16'h0001);
    rd(8'h21, 8'h17);
    pulse(5'h10, 3'h0, 16'h0000);
    rd(8'h21, 8'h10);
  endtask : t_irq

  // watchdog on the whole run
  initial
  begin
    #3000000;
    n_errors++;
    finish_test();
  end

  initial
  begin
    repeat (4) @(posedge REF_CLK);
    RESET <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    u_host.idle_clocks(10);
    t_reset();
    t_mailbox();
    t_error();
    t_overflow();
    t_irq();
    finish_test();
  end
endmodule : shmb_regs_tb
